// ==== tmr2_pkg.sv ====
// Purpose: constants shared by the timer 2 run and single-shot control block
// Assumes: AHB-Lite register map, 32-bit data, one register to a word
// Notes:   bit positions, offsets and register reset values live here; flag and pin resets are literals
package tmr2_pkg;
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_CFG    = 8'h04;
    localparam logic [7:0]  ADDR_COUNT  = 8'h08;
    localparam logic [7:0]  ADDR_RELOAD = 8'h0C;
    localparam logic [7:0]  ADDR_CMP    = 8'h10;
    localparam logic [7:0]  ADDR_STAT   = 8'h14;
    // timer_ctrl_a fields
    localparam int          CTRL_GATE   = 0;
    localparam int          CTRL_SS     = 1;
    localparam int          CTRL_CPRL   = 2;
    localparam int          CTRL_RUN    = 3;
    localparam int          CTRL_RUNL   = 4;
    localparam int          CTRL_POL0   = 5;
    localparam int          CTRL_OE0    = 6;
    // configuration fields
    localparam int          CFG_CT      = 0;
    localparam int          CFG_DUAL    = 1;
    localparam int          CFG_EDGE    = 2;
    localparam int          CFG_CAPT    = 4;
    localparam int          CFG_OE1     = 5;
    localparam int          CFG_POL1    = 6;
    // status fields
    localparam int          STAT_OVF    = 0;
    localparam int          STAT_CAP    = 1;
    localparam int          STAT_SS     = 2;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  CFG_RST     = 8'h00;
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [1:0]  EDGE_BOTH   = 2'h3;
    localparam logic [15:0] COUNT_TOP   = 16'hFFFF;
    localparam logic [7:0]  BYTE_TOP    = 8'hFF;
    typedef enum logic [1:0] {SS_IDLE, SS_ARM, SS_RUN} tmr2_ss_e;
endpackage : tmr2_pkg

// ==== tmr2_ctrl.sv ====
// Purpose: timer 2 run enables, single-shot, capture/reload and pin control
// Assumes: AHB-Lite slave, zero wait states, pin input async to sys_clk_in
// Notes:   one timer tick per clock in timer mode
// Summary of operation
// - compare single-shot emits one reload-to-overflow period
// - compare single-shot waits for gate removal
// - no gated compare single-shot in dual mode
// - capture single-shot halts until edge/gate removal
// - running capture single-shot ends on next edge
// - single-shot delays run or overrides stopped run
// - both-edge capture: polarity picks single-shot edge
// - no flag on single-shot start edge
// - capture-reload select adds reload to capture
// - both-edge gated capture skips reload on one edge
// - main run drives high byte in dual mode
// - stopped timer holds its count
// - low run enable only in dual mode
// - polarity sets starting output level
// - polarity reaches pin on output-enable rise
// - polarity picks gating level, not both-edge
// - gating only with output off, timer mode
`timescale 1ns/1ps
module tmr2_ctrl (
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        timer_pin_primary_in,
    output logic             timer_pin_primary_out,
    output logic             timer_pin_primary_oe_out,
    output logic             timer_pin_secondary_out,
    output logic             timer_pin_secondary_oe_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  ctrl_reg, cfg_reg;
    logic [15:0] count_reg, reload_reg, cmp_reg;
    logic        ovf_flag_reg, cap_flag_reg;
    logic        dp_wr_reg;
    logic [7:0]  dp_addr_reg;
    logic        pin_s1_reg, pin_s2_reg, pin_prev_reg;
    logic        gated_prev_reg, oe0_prev_reg, oe1_prev_reg;
    logic        pol0_lat_reg, pol1_lat_reg;
    tmr2_pkg::tmr2_ss_e ss_reg;

    logic        ap, wr_ctrl, wr_cfg, wr_count, wr_reload, wr_cmp, wr_stat;
    logic        rise, fall, cap_edge, ss_edge, gated, gated_ss, gate_fall;
    logic        capt, dual, tick, en_h, inc_h, inc_l, ovf_h, ovf_l;
    logic        ss_start, cap_now, skip, reload_cap, load_ss, hit_h, hit_l;
    logic [1:0]  edge_sel;
    logic [31:0] rd_mux;

    function automatic logic edge_hit(input logic [1:0] sel, input logic r,
                                      input logic f);
        edge_hit = (sel[0] & r) | (sel[1] & f);
    endfunction : edge_hit

    ////////////////////////////////////////////////////////////////////////
    // bus slave
    assign ap        = hsel_in & htrans_in[1] & hready_in;
    assign wr_ctrl   = dp_wr_reg & (dp_addr_reg == tmr2_pkg::ADDR_CTRL);
    assign wr_cfg    = dp_wr_reg & (dp_addr_reg == tmr2_pkg::ADDR_CFG);
    assign wr_count  = dp_wr_reg & (dp_addr_reg == tmr2_pkg::ADDR_COUNT);
    assign wr_reload = dp_wr_reg & (dp_addr_reg == tmr2_pkg::ADDR_RELOAD);
    assign wr_cmp    = dp_wr_reg & (dp_addr_reg == tmr2_pkg::ADDR_CMP);
    assign wr_stat   = dp_wr_reg & (dp_addr_reg == tmr2_pkg::ADDR_STAT);

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dp_wr_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else begin
            dp_wr_reg   <= ap & hwrite_in;
            dp_addr_reg <= haddr_in[7:0];
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr_in[7:0])
            tmr2_pkg::ADDR_CTRL: begin
                rd_mux[7:0] = ctrl_reg;
                rd_mux[tmr2_pkg::CTRL_SS] = (ss_reg != tmr2_pkg::SS_IDLE);
            end
            tmr2_pkg::ADDR_CFG:    rd_mux[7:0]  = cfg_reg;
            tmr2_pkg::ADDR_COUNT:  rd_mux[15:0] = count_reg;
            tmr2_pkg::ADDR_RELOAD: rd_mux[15:0] = reload_reg;
            tmr2_pkg::ADDR_CMP:    rd_mux[15:0] = cmp_reg;
            tmr2_pkg::ADDR_STAT: begin
                rd_mux[tmr2_pkg::STAT_OVF] = ovf_flag_reg;
                rd_mux[tmr2_pkg::STAT_CAP] = cap_flag_reg;
                rd_mux[tmr2_pkg::STAT_SS]  = (ss_reg != tmr2_pkg::SS_IDLE);
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data sampled in the address phase: a read right after a write
    // to the same word returns the value before that write
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hrdata_out    <= 32'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end else if (ap & ~hwrite_in) begin
            hrdata_out    <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers; the single-shot bit lives in the state machine
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_reg   <= tmr2_pkg::CTRL_RST;
            cfg_reg    <= tmr2_pkg::CFG_RST;
            reload_reg <= tmr2_pkg::COUNT_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= hwdata_in[7:0] & ~(8'h01 << tmr2_pkg::CTRL_SS);
            end
            if (wr_cfg) begin
                cfg_reg <= hwdata_in[7:0];
            end
            if (wr_reload) begin
                reload_reg <= hwdata_in[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser; only pin_s2_reg reads the first stage
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_s1_reg     <= 1'b0;
            pin_s2_reg     <= 1'b0;
            pin_prev_reg   <= 1'b0;
            gated_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg     <= timer_pin_primary_in;
            pin_s2_reg     <= pin_s1_reg;
            pin_prev_reg   <= pin_s2_reg;
            gated_prev_reg <= gated;
        end
    end

    assign rise     = pin_s2_reg & ~pin_prev_reg;
    assign fall     = ~pin_s2_reg & pin_prev_reg;
    assign edge_sel = cfg_reg[tmr2_pkg::CFG_EDGE +: 2];
    assign capt     = cfg_reg[tmr2_pkg::CFG_CAPT];
    assign dual     = cfg_reg[tmr2_pkg::CFG_DUAL];
    assign cap_edge = edge_hit(edge_sel, rise, fall);
    assign ss_edge  = (edge_sel == tmr2_pkg::EDGE_BOTH) ?
                      (ctrl_reg[tmr2_pkg::CTRL_POL0] ? fall : rise) : cap_edge;
    // gating level equal to polarity holds the clock off
    assign gated    = ctrl_reg[tmr2_pkg::CTRL_GATE] & ~ctrl_reg[tmr2_pkg::CTRL_OE0]
                    & ~cfg_reg[tmr2_pkg::CFG_CT] & (edge_sel != tmr2_pkg::EDGE_BOTH)
                    & (pin_s2_reg == ctrl_reg[tmr2_pkg::CTRL_POL0]);
    assign gated_ss  = gated & ~dual;
    assign gate_fall = gated_prev_reg & ~gated;

    ////////////////////////////////////////////////////////////////////////
    // single-shot sequencer; ignored in counter mode
    assign ss_start = wr_ctrl & hwdata_in[tmr2_pkg::CTRL_SS]
                    & ~cfg_reg[tmr2_pkg::CFG_CT];

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ss_reg <= tmr2_pkg::SS_IDLE;
        end else begin
            case (ss_reg)
                tmr2_pkg::SS_IDLE: begin
                    if (ss_start) begin
                        ss_reg <= tmr2_pkg::SS_ARM;
                    end
                end
                tmr2_pkg::SS_ARM: begin
                    if (capt ? (ss_edge | gate_fall) : ~gated_ss) begin
                        ss_reg <= tmr2_pkg::SS_RUN;
                    end
                end
                tmr2_pkg::SS_RUN: begin
                    if (capt ? ss_edge : ovf_h) begin
                        ss_reg <= tmr2_pkg::SS_IDLE;
                    end
                end
                default: ss_reg <= tmr2_pkg::SS_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counting
    assign tick  = cfg_reg[tmr2_pkg::CFG_CT] ? rise : 1'b1;
    // armed single-shot halts; running single-shot overrides a stopped run
    assign en_h  = (ss_reg == tmr2_pkg::SS_RUN) ? ~gated :
                   (ss_reg == tmr2_pkg::SS_ARM) ? 1'b0 :
                   (ctrl_reg[tmr2_pkg::CTRL_RUN] & ~gated);
    assign inc_h = en_h & tick;
    assign inc_l = dual & ctrl_reg[tmr2_pkg::CTRL_RUNL] & tick;
    assign ovf_h = inc_h & (dual ? (count_reg[15:8] == tmr2_pkg::BYTE_TOP)
                                 : (count_reg == tmr2_pkg::COUNT_TOP));
    assign ovf_l = inc_l & (count_reg[7:0] == tmr2_pkg::BYTE_TOP);
    assign load_ss = (ss_reg == tmr2_pkg::SS_ARM) & ~capt & ~gated_ss;

    // capture on the chosen edge; the single-shot start edge is not one
    assign cap_now = capt & (((ss_reg == tmr2_pkg::SS_IDLE) & cap_edge)
                   | ((ss_reg == tmr2_pkg::SS_RUN) & ss_edge));
    assign skip    = (edge_sel == tmr2_pkg::EDGE_BOTH) & ctrl_reg[tmr2_pkg::CTRL_GATE]
                   & (ctrl_reg[tmr2_pkg::CTRL_POL0] ? rise : fall);
    assign reload_cap = cap_now & ctrl_reg[tmr2_pkg::CTRL_CPRL] & ~skip;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_reg <= tmr2_pkg::COUNT_RST;
        end else if (wr_count) begin
            count_reg <= hwdata_in[15:0];
        end else if (reload_cap | load_ss) begin
            count_reg <= reload_reg;
        end else if (~dual) begin
            if (inc_h) begin
                count_reg <= ovf_h ? reload_reg : count_reg + 16'h0001;
            end
        end else begin
            if (inc_h) begin
                count_reg[15:8] <= ovf_h ? reload_reg[15:8] : count_reg[15:8] + 8'h01;
            end
            if (inc_l) begin
                count_reg[7:0] <= ovf_l ? reload_reg[7:0] : count_reg[7:0] + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cmp_reg <= tmr2_pkg::COUNT_RST;
        end else if (cap_now) begin
            cmp_reg <= count_reg;
        end else if (wr_cmp) begin
            cmp_reg <= hwdata_in[15:0];
        end
    end

    // sticky flags, write one to clear; a set in the same cycle wins
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ovf_flag_reg <= 1'b0;
            cap_flag_reg <= 1'b0;
        end else begin
            ovf_flag_reg <= ovf_h | (ovf_flag_reg
                          & ~(wr_stat & hwdata_in[tmr2_pkg::STAT_OVF]));
            cap_flag_reg <= cap_now | (cap_flag_reg
                          & ~(wr_stat & hwdata_in[tmr2_pkg::STAT_CAP]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin outputs; polarity is latched only on an enable rise
    assign hit_h = dual ? (count_reg[15:8] >= cmp_reg[15:8]) : (count_reg >= cmp_reg);
    assign hit_l = dual ? (count_reg[7:0] >= cmp_reg[7:0]) : hit_h;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            oe0_prev_reg               <= 1'b0;
            oe1_prev_reg               <= 1'b0;
            pol0_lat_reg               <= 1'b0;
            pol1_lat_reg               <= 1'b0;
            timer_pin_primary_out      <= 1'b0;
            timer_pin_primary_oe_out   <= 1'b0;
            timer_pin_secondary_out    <= 1'b0;
            timer_pin_secondary_oe_out <= 1'b0;
        end else begin
            oe0_prev_reg <= ctrl_reg[tmr2_pkg::CTRL_OE0];
            oe1_prev_reg <= cfg_reg[tmr2_pkg::CFG_OE1];
            if (ctrl_reg[tmr2_pkg::CTRL_OE0] & ~oe0_prev_reg) begin
                pol0_lat_reg <= ctrl_reg[tmr2_pkg::CTRL_POL0];
            end
            if (cfg_reg[tmr2_pkg::CFG_OE1] & ~oe1_prev_reg) begin
                pol1_lat_reg <= cfg_reg[tmr2_pkg::CFG_POL1];
            end
            timer_pin_primary_out      <= pol0_lat_reg ^ (~capt & hit_h);
            timer_pin_secondary_out    <= pol1_lat_reg ^ (~capt & hit_l);
            timer_pin_primary_oe_out   <= ctrl_reg[tmr2_pkg::CTRL_OE0];
            timer_pin_secondary_oe_out <= cfg_reg[tmr2_pkg::CFG_OE1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_hold_stopped: assert property (~ctrl_reg[tmr2_pkg::CTRL_RUN]
        && ss_reg == tmr2_pkg::SS_IDLE && ~dual && ~wr_count && ~cap_now
        |=> $stable(count_reg)) else $error("stopped timer moved");
    a_ss_cap_halt: assert property (ss_reg == tmr2_pkg::SS_ARM && capt
        && ~wr_count && ~ss_edge && ~gate_fall
        |=> $stable(count_reg) && ss_reg == tmr2_pkg::SS_ARM)
        else $error("armed capture single-shot not halted");
    a_ss_cap_end: assert property (ss_reg == tmr2_pkg::SS_RUN && capt && ss_edge
        |=> ss_reg == tmr2_pkg::SS_IDLE && cap_flag_reg
            && cmp_reg == $past(count_reg)) else $error("single-shot end missed");
    a_no_start_flag: assert property (ss_reg == tmr2_pkg::SS_ARM && ~cap_flag_reg
        && ~wr_stat |=> ~cap_flag_reg) else $error("flag set on start edge");
    a_ss_cmp_start: assert property (ss_reg == tmr2_pkg::SS_ARM && ~capt
        && ~gated_ss && ~wr_count |=> ss_reg == tmr2_pkg::SS_RUN
            && count_reg == $past(reload_reg)) else $error("compare single-shot start");
    a_dual_high_hold: assert property (dual && ~ctrl_reg[tmr2_pkg::CTRL_RUN]
        && ss_reg == tmr2_pkg::SS_IDLE && ~wr_count && ~cap_now
        |=> count_reg[15:8] == $past(count_reg[15:8])) else $error("high byte moved");
    a_low_run: assert property (~dual && ~wr_count && ~cap_now
        && ss_reg == tmr2_pkg::SS_IDLE && ~ctrl_reg[tmr2_pkg::CTRL_RUN]
        && ctrl_reg[tmr2_pkg::CTRL_RUNL] |=> $stable(count_reg))
        else $error("low run acted in 16-bit mode");
    a_pol_latch: assert property ($rose(ctrl_reg[tmr2_pkg::CTRL_OE0])
        |=> pol0_lat_reg == $past(ctrl_reg[tmr2_pkg::CTRL_POL0])
            ##1 timer_pin_primary_oe_out) else $error("polarity not latched");
    a_gate_hold: assert property (gated && ss_reg == tmr2_pkg::SS_IDLE && ~dual
        && ~wr_count && ~cap_now |=> $stable(count_reg)) else $error("gate ignored");
    a_reload_skip: assert property (capt && skip && cap_now && ~wr_count
        && ~load_ss |=> count_reg != $past(reload_reg) || $past(count_reg) ==
            $past(reload_reg) || $past(inc_h)) else $error("skipped reload done");

    c_ss_capture: cover property (ss_reg == tmr2_pkg::SS_RUN && capt && ss_edge);
    c_ss_compare: cover property (ss_reg == tmr2_pkg::SS_RUN && ~capt && ovf_h);
    c_cap_reload: cover property (reload_cap && ss_reg == tmr2_pkg::SS_IDLE);
    c_dual_both:  cover property (dual && inc_h && inc_l);
endmodule : tmr2_ctrl

// ==== tmr2_pin_model.sv ====
// Purpose: far-side model of the primary timer pin
// Assumes: the block drives the pin only while its output enable is high
// Notes:   the external source backs off while the block drives the pin
`timescale 1ns/1ps
module tmr2_pin_model (
    input  wire logic pin_oe_in,
    input  wire logic pin_drv_in,
    input  wire logic ext_level_in,
    output logic      pin_level_out
);
    ////////////////////////////////////////////////////////////////////////
    // wire level resolved from both drivers, block wins when enabled
    always_comb begin
        pin_level_out = pin_oe_in ? pin_drv_in : ext_level_in;
    end
endmodule : tmr2_pin_model

// ==== timer2_run_single_shot_control_tb_top.sv ====
// Purpose: self-checking bench for the timer 2 run and single-shot block
// Assumes: zero-wait AHB-Lite slave, pin seen three edges after it moves
// Notes:   waits of 6 cycles cover the pin synchroniser latency
`timescale 1ns/1ps
module timer2_run_single_shot_control_tb_top;
    logic        sys_clk_in;
    logic        sys_rst_in;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe;
    logic        ext_level;
    logic        pin2_out;
    logic        pin2_oe;
    logic [31:0] rd;
    logic [31:0] rd2;
    int          err_count;
    int          check_count;

    tmr2_ctrl dut_u (
        .sys_clk_in                 (sys_clk_in),
        .sys_rst_in                 (sys_rst_in),
        .hsel_in                    (1'b1),
        .haddr_in                   (haddr),
        .htrans_in                  (htrans),
        .hwrite_in                  (hwrite),
        .hsize_in                   (3'h2),
        .hwdata_in                  (hwdata),
        .hready_in                  (hready),
        .hrdata_out                 (hrdata),
        .hreadyout_out              (hready),
        .hresp_out                  (hresp),
        .timer_pin_primary_in       (pin_in),
        .timer_pin_primary_out      (pin_out),
        .timer_pin_primary_oe_out   (pin_oe),
        .timer_pin_secondary_out    (pin2_out),
        .timer_pin_secondary_oe_out (pin2_oe)
    );

    tmr2_pin_model pin_u (
        .pin_oe_in     (pin_oe),
        .pin_drv_in    (pin_out),
        .ext_level_in  (ext_level),
        .pin_level_out (pin_in)
    );

    ////////////////////////////////////////////////////////////////////////
    initial sys_clk_in = 1'b0;
    always #10 sys_clk_in = ~sys_clk_in;

    function automatic logic [31:0] bv(input int p);
        bv = 32'h1 << p;
    endfunction : bv

    task automatic report_and_stop;
        if (err_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : cyc

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge sys_clk_in);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_count++;
                report_and_stop();
            end
            @(posedge sys_clk_in);
        end
    endtask : wait_rdy

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= 1'b1;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= 1'b0;
        wait_rdy();
        htrans <= 2'h0;
        wait_rdy();
        d = hrdata;
    endtask : bus_rd

    task automatic set_pin(input logic v);
        ext_level <= v;
        cyc(6);
    endtask : set_pin

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus_rd(a, rd);
        check(rd, exp);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        err_count   = 0;
        check_count = 0;
        sys_rst_in  = 1'b1;
        haddr       = 32'h00000000;
        htrans      = 2'h0;
        hwrite      = 1'b0;
        hwdata      = 32'h00000000;
        ext_level   = 1'b0;
        cyc(2);
        sys_rst_in <= 1'b0;
        cyc(1);
        rd_chk(tmr2_pkg::ADDR_CTRL, 32'h00000000);
        rd_chk(tmr2_pkg::ADDR_STAT, 32'h00000000);
        bus_wr(8'h18, 32'h000000FF);
        rd_chk(8'h18, 32'h00000000);
        // stopped timer holds a written count, low run ignored in 16-bit mode
        bus_wr(tmr2_pkg::ADDR_COUNT, 32'h00001234);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_RUNL));
        cyc(10);
        rd_chk(tmr2_pkg::ADDR_COUNT, 32'h00001234);
        // dual mode: low run moves only the low byte
        bus_wr(tmr2_pkg::ADDR_CFG, bv(tmr2_pkg::CFG_DUAL));
        bus_wr(tmr2_pkg::ADDR_COUNT, 32'h00001010);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_RUNL));
        cyc(5);
        bus_wr(tmr2_pkg::ADDR_CTRL, 32'h00000000);
        bus_rd(tmr2_pkg::ADDR_COUNT, rd);
        check({24'h0, rd[15:8]}, 32'h00000010);
        check({31'h0, rd[7:0] !== 8'h10}, 32'h00000001);
        // dual mode: main run moves only the high byte
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_RUN));
        cyc(5);
        bus_wr(tmr2_pkg::ADDR_CTRL, 32'h00000000);
        bus_rd(tmr2_pkg::ADDR_COUNT, rd2);
        check({24'h0, rd2[7:0]}, {24'h0, rd[7:0]});
        check({31'h0, rd2[15:8] !== 8'h10}, 32'h00000001);
        // gating holds a running timer only while the output is off
        bus_wr(tmr2_pkg::ADDR_CFG, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_COUNT, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_GATE) | bv(tmr2_pkg::CTRL_RUN));
        cyc(10);
        rd_chk(tmr2_pkg::ADDR_COUNT, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_GATE) | bv(tmr2_pkg::CTRL_RUN)
               | bv(tmr2_pkg::CTRL_OE0));
        cyc(10);
        bus_rd(tmr2_pkg::ADDR_COUNT, rd);
        check({31'h0, rd !== 32'h0}, 32'h00000001);
        // polarity latched only on output-enable rise
        bus_wr(tmr2_pkg::ADDR_CTRL, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_COUNT, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_CMP, 32'h0000FFFF);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_POL0) | bv(tmr2_pkg::CTRL_OE0));
        cyc(3);
        check({30'h0, pin_oe, pin_out}, 32'h00000003);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_OE0));
        cyc(3);
        check({31'h0, pin_out}, 32'h00000001);
        bus_wr(tmr2_pkg::ADDR_CTRL, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_OE0));
        cyc(3);
        check({31'h0, pin_out}, 32'h00000000);
        // single-shot refused in counter mode
        bus_wr(tmr2_pkg::ADDR_CTRL, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_CFG, bv(tmr2_pkg::CFG_CT));
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_SS));
        rd_chk(tmr2_pkg::ADDR_STAT, 32'h00000000);
        // compare single-shot runs reload to overflow once
        bus_wr(tmr2_pkg::ADDR_CFG, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_RELOAD, 32'h0000FFF0);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_SS));
        cyc(40);
        bus_rd(tmr2_pkg::ADDR_STAT, rd);
        check(rd & 32'h5, 32'h00000001);
        // gated compare single-shot waits for the pin to leave the gate level
        bus_wr(tmr2_pkg::ADDR_STAT, 32'h00000007);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_GATE) | bv(tmr2_pkg::CTRL_SS));
        cyc(40);
        bus_rd(tmr2_pkg::ADDR_STAT, rd);
        check(rd & 32'h5, 32'h00000004);
        set_pin(1'b1);
        cyc(40);
        bus_rd(tmr2_pkg::ADDR_STAT, rd);
        check(rd & 32'h5, 32'h00000001);
        // capture single-shot on rising edges, with reload
        set_pin(1'b0);
        // drop gating while idle: a gate release seen while armed would start the cycle
        bus_wr(tmr2_pkg::ADDR_CTRL, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_STAT, 32'h00000007);
        bus_wr(tmr2_pkg::ADDR_RELOAD, 32'h00000100);
        bus_wr(tmr2_pkg::ADDR_COUNT, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_CFG, bv(tmr2_pkg::CFG_CAPT) | bv(tmr2_pkg::CFG_EDGE));
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_SS) | bv(tmr2_pkg::CTRL_CPRL));
        cyc(10);
        rd_chk(tmr2_pkg::ADDR_COUNT, 32'h00000000);
        set_pin(1'b1);
        rd_chk(tmr2_pkg::ADDR_STAT, 32'h00000004);
        set_pin(1'b0);
        bus_rd(tmr2_pkg::ADDR_COUNT, rd);
        check({31'h0, rd !== 32'h0}, 32'h00000001);
        set_pin(1'b1);
        rd_chk(tmr2_pkg::ADDR_STAT, 32'h00000002);
        rd_chk(tmr2_pkg::ADDR_COUNT, 32'h00000100);
        bus_rd(tmr2_pkg::ADDR_CMP, rd);
        check({31'h0, rd !== 32'h0}, 32'h00000001);
        // both edges, polarity 1: falling edge starts the cycle
        set_pin(1'b0);
        bus_wr(tmr2_pkg::ADDR_COUNT, 32'h00000000);
        bus_wr(tmr2_pkg::ADDR_CFG, bv(tmr2_pkg::CFG_CAPT) | 32'h0000000C);
        bus_wr(tmr2_pkg::ADDR_CTRL, bv(tmr2_pkg::CTRL_SS) | bv(tmr2_pkg::CTRL_POL0));
        set_pin(1'b1);
        rd_chk(tmr2_pkg::ADDR_COUNT, 32'h00000000);
        set_pin(1'b0);
        bus_rd(tmr2_pkg::ADDR_COUNT, rd);
        check({31'h0, rd !== 32'h0}, 32'h00000001);
        // secondary pin: capture mode shows the latched polarity level
        bus_wr(tmr2_pkg::ADDR_CFG, bv(tmr2_pkg::CFG_CAPT) | bv(tmr2_pkg::CFG_OE1)
               | bv(tmr2_pkg::CFG_POL1));
        cyc(3);
        check({29'h0, hresp, pin2_oe, pin2_out}, 32'h00000003);
        report_and_stop();
    end
endmodule : timer2_run_single_shot_control_tb_top
